// ### design/ucb_map.svh
`ifndef UCB_MAP_SVH
`define UCB_MAP_SVH
// register offsets on the 3-bit register port
`define UCB_ADDR_DATA 3'h0
`define UCB_ADDR_IRQ_EN 3'h1
`define UCB_ADDR_FIFO_CTL 3'h2
`define UCB_ADDR_LINE_CTL 3'h3
`define UCB_ADDR_DIV_LO 3'h4
`define UCB_ADDR_DIV_HI 3'h5
`define UCB_ADDR_LINE_STAT 3'h6
`define UCB_ADDR_SCRATCH 3'h7
// field positions
`define UCB_IRQ_EN_RX 0
`define UCB_IRQ_EN_TX 1
`define UCB_FIFO_CTL_EN 0
`define UCB_FIFO_CTL_RX_CLR 1
`define UCB_FIFO_CTL_TX_CLR 2
// reset values
`define UCB_DIV_RESET 16'h0000
`define UCB_LINE_CTL_RESET 8'h03
`define UCB_BYTE_RESET 8'h00
// buffer depth and bit timing in 16x ticks
`define UCB_FIFO_DEPTH 5'h10
`define UCB_TICK_LAST 4'hF
`define UCB_TICK_HALF 4'h7
`endif

// ### design/ucb_pkg.sv
package ucb_pkg;
  typedef enum logic [2:0] {
    UCB_TX_IDLE = 3'b000,
    UCB_TX_START = 3'b001,
    UCB_TX_DATA = 3'b010,
    UCB_TX_PARITY = 3'b011,
    UCB_TX_STOP = 3'b100
  } ucb_tx_state_e;
  typedef enum logic [2:0] {
    UCB_RX_IDLE = 3'b000,
    UCB_RX_START = 3'b001,
    UCB_RX_DATA = 3'b010,
    UCB_RX_PARITY = 3'b011,
    UCB_RX_STOP = 3'b100
  } ucb_rx_state_e;
  typedef struct packed {
    logic [2:0] spare;
    logic even_parity;
    logic parity_en;
    logic two_stop;
    logic [1:0] word_len;
  } ucb_lcr_s;
endpackage : ucb_pkg

// ### design/ucb_uart.sv
// The register offsets and strobed register access were chosen for this implementation.
`include "ucb_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ucb_uart (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // clock pins
  input wire logic reference_clock_in,
  input wire logic receiver_clock_in,
  // serial line
  input wire logic serial_input,
  output logic serial_output,
  output logic baud_clock_out,
  // interrupt request
  output logic irq_out
);
  function automatic logic [3:0] data_bits(input logic [1:0] wl);
    data_bits = 4'h5 + {2'b00, wl};
  endfunction : data_bits

  // char mode behaves as a one-deep holding register
  function automatic logic [4:0] fifo_limit(input logic fifo_en);
    fifo_limit = fifo_en ? `UCB_FIFO_DEPTH : 5'h01;
  endfunction : fifo_limit

  logic ref_meta_reg, ref_sync_reg, ref_last_reg;
  logic rck_meta_reg, rck_sync_reg, rck_last_reg;
  logic sin_meta_reg, sin_sync_reg;
  logic ref_edge, rx_tick;
  logic [15:0] div_reg, baud_cnt_reg;
  logic [7:0] ier_reg, fcr_reg, scratch_pad_reg;
  ucb_pkg::ucb_lcr_s lcr_reg;
  logic wr_div;
  logic [7:0] rx_mem [0:15];
  logic [7:0] tx_mem [0:15];
  logic [3:0] rx_wp_reg, rx_rp_reg, tx_wp_reg, tx_rp_reg;
  logic [4:0] rx_count_reg, tx_count_reg;
  logic rx_push, rx_pop, tx_push, tx_pop, rx_full;
  logic [7:0] rx_word;
  ucb_pkg::ucb_tx_state_e tx_state_reg;
  ucb_pkg::ucb_rx_state_e rx_state_reg;
  logic [7:0] transmit_shifter_reg, receive_shifter_reg;
  logic [3:0] tx_tick_reg, rx_tick_reg;
  logic [2:0] tx_bit_reg, rx_bit_reg;
  logic tx_par_reg, rx_par_reg, tx_stop2_reg;
  logic overrun_reg, parity_err_reg, frame_err_reg;
  logic rx_avail, tx_empty, irq_next;
  logic [7:0] rdata_next, line_status;

  assign ref_edge = ref_sync_reg & ~ref_last_reg;
  assign rx_tick = rck_sync_reg & ~rck_last_reg;
  assign wr_div = reg_wr && (reg_addr == `UCB_ADDR_DIV_LO || reg_addr == `UCB_ADDR_DIV_HI);

  // clock pins are slow against core_clk, so rising edges become enables
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ref_meta_reg <= 1'b0;
      ref_sync_reg <= 1'b0;
      ref_last_reg <= 1'b0;
      rck_meta_reg <= 1'b0;
      rck_sync_reg <= 1'b0;
      rck_last_reg <= 1'b0;
      sin_meta_reg <= 1'b1;
      sin_sync_reg <= 1'b1;
    end else begin
      ref_meta_reg <= reference_clock_in;
      ref_sync_reg <= ref_meta_reg;
      ref_last_reg <= ref_sync_reg;
      rck_meta_reg <= receiver_clock_in;
      rck_sync_reg <= rck_meta_reg;
      rck_last_reg <= rck_sync_reg;
      sin_meta_reg <= serial_input;
      sin_sync_reg <= sin_meta_reg;
    end
  end

  // control registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= `UCB_DIV_RESET;
      ier_reg <= `UCB_BYTE_RESET;
      fcr_reg <= `UCB_BYTE_RESET;
      lcr_reg <= `UCB_LINE_CTL_RESET;
      scratch_pad_reg <= `UCB_BYTE_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `UCB_ADDR_DIV_LO) begin
        div_reg[7:0] <= reg_wdata;
      end else if (reg_addr == `UCB_ADDR_DIV_HI) begin
        div_reg[15:8] <= reg_wdata;
      end else if (reg_addr == `UCB_ADDR_IRQ_EN) begin
        ier_reg <= {6'h00, reg_wdata[1:0]};
      end else if (reg_addr == `UCB_ADDR_FIFO_CTL) begin
        fcr_reg <= {reg_wdata[7:6], 5'h00, reg_wdata[0]};
      end else if (reg_addr == `UCB_ADDR_LINE_CTL) begin
        lcr_reg <= reg_wdata;
      end else if (reg_addr == `UCB_ADDR_SCRATCH) begin
        scratch_pad_reg <= reg_wdata;
      end
    end
  end

  // divisor zero leaves the generator stopped; software must load it first
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      baud_cnt_reg <= `UCB_DIV_RESET;
      baud_clock_out <= 1'b0;
    end else if (wr_div) begin
      baud_cnt_reg <= (reg_addr == `UCB_ADDR_DIV_LO) ? {div_reg[15:8], reg_wdata}
                                                     : {reg_wdata, div_reg[7:0]};
      baud_clock_out <= 1'b0;
    end else if (ref_edge && div_reg != 16'h0000) begin
      if (baud_cnt_reg <= 16'h0001) begin
        baud_cnt_reg <= div_reg;
        baud_clock_out <= 1'b1;
      end else begin
        baud_cnt_reg <= baud_cnt_reg - 16'h0001;
        baud_clock_out <= 1'b0;
      end
    end else begin
      baud_clock_out <= 1'b0;
    end
  end

  assign rx_full = rx_count_reg >= fifo_limit(fcr_reg[`UCB_FIFO_CTL_EN]);
  assign rx_pop = reg_rd && reg_addr == `UCB_ADDR_DATA && rx_count_reg != 5'h00;
  assign tx_push = reg_wr && reg_addr == `UCB_ADDR_DATA &&
                   tx_count_reg < fifo_limit(fcr_reg[`UCB_FIFO_CTL_EN]);
  assign tx_pop = tx_state_reg == ucb_pkg::UCB_TX_IDLE && tx_count_reg != 5'h00;
  assign rx_word = receive_shifter_reg >> (4'h8 - data_bits(lcr_reg.word_len));

  always_ff @(posedge core_clk) begin
    if (rx_push && !rx_full) begin
      rx_mem[rx_wp_reg] <= rx_word;
    end
    if (tx_push) begin
      tx_mem[tx_wp_reg] <= reg_wdata;
    end
  end

  // receive buffer pointers; an overflowing character is dropped
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_wp_reg <= 4'h0;
      rx_rp_reg <= 4'h0;
      rx_count_reg <= 5'h00;
    end else if (reg_wr && reg_addr == `UCB_ADDR_FIFO_CTL && reg_wdata[`UCB_FIFO_CTL_RX_CLR]) begin
      rx_wp_reg <= 4'h0;
      rx_rp_reg <= 4'h0;
      rx_count_reg <= 5'h00;
    end else begin
      if (rx_push && !rx_full) begin
        rx_wp_reg <= rx_wp_reg + 4'h1;
      end
      if (rx_pop) begin
        rx_rp_reg <= rx_rp_reg + 4'h1;
      end
      rx_count_reg <= rx_count_reg + {4'h0, rx_push && !rx_full} - {4'h0, rx_pop};
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_wp_reg <= 4'h0;
      tx_rp_reg <= 4'h0;
      tx_count_reg <= 5'h00;
    end else if (reg_wr && reg_addr == `UCB_ADDR_FIFO_CTL && reg_wdata[`UCB_FIFO_CTL_TX_CLR]) begin
      tx_wp_reg <= 4'h0;
      tx_rp_reg <= 4'h0;
      tx_count_reg <= 5'h00;
    end else begin
      if (tx_push) begin
        tx_wp_reg <= tx_wp_reg + 4'h1;
      end
      if (tx_pop) begin
        tx_rp_reg <= tx_rp_reg + 4'h1;
      end
      tx_count_reg <= tx_count_reg + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  // transmitter: sixteen baud pulses per bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_state_reg <= ucb_pkg::UCB_TX_IDLE;
      transmit_shifter_reg <= `UCB_BYTE_RESET;
      tx_tick_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_par_reg <= 1'b0;
      tx_stop2_reg <= 1'b0;
      serial_output <= 1'b1;
    end else begin
      case (tx_state_reg)
        ucb_pkg::UCB_TX_IDLE: begin
          serial_output <= 1'b1;
          if (tx_pop) begin
            transmit_shifter_reg <= tx_mem[tx_rp_reg];
            tx_par_reg <= ~lcr_reg.even_parity;
            tx_tick_reg <= 4'h0;
            tx_state_reg <= ucb_pkg::UCB_TX_START;
            serial_output <= 1'b0;
          end
        end
        default: begin
          if (baud_clock_out) begin
            tx_tick_reg <= tx_tick_reg + 4'h1;
            if (tx_tick_reg == `UCB_TICK_LAST) begin
              case (tx_state_reg)
                ucb_pkg::UCB_TX_START: begin
                  tx_bit_reg <= 3'h0;
                  serial_output <= transmit_shifter_reg[0];
                  tx_par_reg <= tx_par_reg ^ transmit_shifter_reg[0];
                  transmit_shifter_reg <= {1'b0, transmit_shifter_reg[7:1]};
                  tx_state_reg <= ucb_pkg::UCB_TX_DATA;
                end
                ucb_pkg::UCB_TX_DATA: begin
                  if ({1'b0, tx_bit_reg} == data_bits(lcr_reg.word_len) - 4'h1) begin
                    tx_stop2_reg <= lcr_reg.two_stop;
                    if (lcr_reg.parity_en) begin
                      serial_output <= tx_par_reg;
                      tx_state_reg <= ucb_pkg::UCB_TX_PARITY;
                    end else begin
                      serial_output <= 1'b1;
                      tx_state_reg <= ucb_pkg::UCB_TX_STOP;
                    end
                  end else begin
                    tx_bit_reg <= tx_bit_reg + 3'h1;
                    serial_output <= transmit_shifter_reg[0];
                    tx_par_reg <= tx_par_reg ^ transmit_shifter_reg[0];
                    transmit_shifter_reg <= {1'b0, transmit_shifter_reg[7:1]};
                  end
                end
                ucb_pkg::UCB_TX_PARITY: begin
                  serial_output <= 1'b1;
                  tx_state_reg <= ucb_pkg::UCB_TX_STOP;
                end
                default: begin
                  serial_output <= 1'b1;
                  if (tx_stop2_reg) begin
                    tx_stop2_reg <= 1'b0;
                  end else begin
                    tx_state_reg <= ucb_pkg::UCB_TX_IDLE;
                  end
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  // receiver: start is checked at mid-bit, then one sample per sixteen ticks
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_state_reg <= ucb_pkg::UCB_RX_IDLE;
      receive_shifter_reg <= `UCB_BYTE_RESET;
      rx_tick_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_par_reg <= 1'b0;
      rx_push <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (rx_tick) begin
        rx_tick_reg <= rx_tick_reg + 4'h1;
        case (rx_state_reg)
          ucb_pkg::UCB_RX_IDLE: begin
            rx_tick_reg <= 4'h0;
            if (!sin_sync_reg) begin
              rx_state_reg <= ucb_pkg::UCB_RX_START;
            end
          end
          ucb_pkg::UCB_RX_START: begin
            if (rx_tick_reg == `UCB_TICK_HALF) begin
              rx_tick_reg <= 4'h0;
              rx_bit_reg <= 3'h0;
              rx_par_reg <= ~lcr_reg.even_parity;
              rx_state_reg <= sin_sync_reg ? ucb_pkg::UCB_RX_IDLE : ucb_pkg::UCB_RX_DATA;
            end
          end
          ucb_pkg::UCB_RX_DATA: begin
            if (rx_tick_reg == `UCB_TICK_LAST) begin
              receive_shifter_reg <= {sin_sync_reg, receive_shifter_reg[7:1]};
              rx_par_reg <= rx_par_reg ^ sin_sync_reg;
              rx_bit_reg <= rx_bit_reg + 3'h1;
              if ({1'b0, rx_bit_reg} == data_bits(lcr_reg.word_len) - 4'h1) begin
                rx_state_reg <= lcr_reg.parity_en ? ucb_pkg::UCB_RX_PARITY
                                                  : ucb_pkg::UCB_RX_STOP;
              end
            end
          end
          ucb_pkg::UCB_RX_PARITY: begin
            if (rx_tick_reg == `UCB_TICK_LAST) begin
              rx_par_reg <= rx_par_reg ^ sin_sync_reg;
              rx_state_reg <= ucb_pkg::UCB_RX_STOP;
            end
          end
          default: begin
            if (rx_tick_reg == `UCB_TICK_LAST) begin
              rx_push <= 1'b1;
              rx_state_reg <= ucb_pkg::UCB_RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // error flags: a new error wins over the clearing status read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      overrun_reg <= 1'b0;
      parity_err_reg <= 1'b0;
      frame_err_reg <= 1'b0;
    end else begin
      if (reg_rd && reg_addr == `UCB_ADDR_LINE_STAT) begin
        overrun_reg <= 1'b0;
        parity_err_reg <= 1'b0;
        frame_err_reg <= 1'b0;
      end
      if (rx_push && rx_full) begin
        overrun_reg <= 1'b1;
      end
      if (rx_tick && rx_state_reg == ucb_pkg::UCB_RX_STOP && rx_tick_reg == `UCB_TICK_LAST) begin
        if (!sin_sync_reg) begin
          frame_err_reg <= 1'b1;
        end
        if (lcr_reg.parity_en && rx_par_reg) begin
          parity_err_reg <= 1'b1;
        end
      end
    end
  end

  assign line_status = {1'b0, tx_empty && tx_state_reg == ucb_pkg::UCB_TX_IDLE, tx_empty, 1'b0,
                        frame_err_reg, parity_err_reg, overrun_reg, rx_count_reg != 5'h00};
  assign tx_empty = tx_count_reg == 5'h00;

  always_comb begin
    // fifo mode compares against the programmed trigger level
    if (fcr_reg[`UCB_FIFO_CTL_EN]) begin
      case (fcr_reg[7:6])
        2'h0: rx_avail = rx_count_reg >= 5'h01;
        2'h1: rx_avail = rx_count_reg >= 5'h04;
        2'h2: rx_avail = rx_count_reg >= 5'h08;
        default: rx_avail = rx_count_reg >= 5'h0E;
      endcase
    end else begin
      rx_avail = rx_count_reg != 5'h00;
    end
    irq_next = (ier_reg[`UCB_IRQ_EN_RX] && rx_avail) ||
               (ier_reg[`UCB_IRQ_EN_TX] && tx_empty);
  end

  always_comb begin
    if (reg_addr == `UCB_ADDR_DATA) begin
      rdata_next = (rx_count_reg != 5'h00) ? rx_mem[rx_rp_reg] : 8'h00;
    end else if (reg_addr == `UCB_ADDR_IRQ_EN) begin
      rdata_next = ier_reg;
    end else if (reg_addr == `UCB_ADDR_FIFO_CTL) begin
      rdata_next = fcr_reg;
    end else if (reg_addr == `UCB_ADDR_LINE_CTL) begin
      rdata_next = lcr_reg;
    end else if (reg_addr == `UCB_ADDR_DIV_LO) begin
      rdata_next = div_reg[7:0];
    end else if (reg_addr == `UCB_ADDR_DIV_HI) begin
      rdata_next = div_reg[15:8];
    end else if (reg_addr == `UCB_ADDR_LINE_STAT) begin
      rdata_next = line_status;
    end else begin
      rdata_next = scratch_pad_reg;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      irq_out <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
      irq_out <= irq_next;
    end
  end

  property p_div_reload;
    @(posedge core_clk) disable iff (!nrst) wr_div |=> baud_cnt_reg == div_reg;
  endproperty
  a_div_reload: assert property (p_div_reload) else $error("counter not reloaded");
  property p_baud_pulse;
    @(posedge core_clk) disable iff (!nrst)
      (ref_edge && !wr_div && div_reg != 16'h0000 && baud_cnt_reg <= 16'h0001)
      |=> baud_clock_out ##1 !baud_clock_out;
  endproperty
  a_baud_pulse: assert property (p_baud_pulse) else $error("baud pulse wrong");
  property p_div_hold;
    @(posedge core_clk) disable iff (!nrst)
      (reg_wr && reg_addr == `UCB_ADDR_DIV_HI) |=> div_reg[15:8] == $past(reg_wdata);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("high latch lost");
  property p_scratch;
    @(posedge core_clk) disable iff (!nrst)
      (reg_wr && reg_addr == `UCB_ADDR_SCRATCH) ##1 (reg_rd && reg_addr == `UCB_ADDR_SCRATCH)
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch readback wrong");
  property p_rx_irq;
    @(posedge core_clk) disable iff (!nrst)
      (!fcr_reg[0] && ier_reg[0] && rx_count_reg != 5'h00) |=> irq_out;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");
  property p_tx_clear;
    @(posedge core_clk) disable iff (!nrst)
      (!fcr_reg[0] && !ier_reg[0] && tx_push) |=> ##1 !irq_out;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx irq not cleared");
  // a busy shifter must leave the holding buffer alone; only a clear may empty it
  property p_load_idle;
    @(posedge core_clk) disable iff (!nrst)
      (tx_state_reg != ucb_pkg::UCB_TX_IDLE && !(reg_wr && reg_addr == `UCB_ADDR_FIFO_CTL))
      |=> tx_count_reg >= $past(tx_count_reg);
  endproperty
  a_load_idle: assert property (p_load_idle) else $error("load while busy");
  property p_start_low;
    @(posedge core_clk) disable iff (!nrst)
      tx_pop |=> (!serial_output && tx_state_reg == ucb_pkg::UCB_TX_START);
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit missing");
  property p_cap;
    @(posedge core_clk) disable iff (!nrst)
      rx_count_reg <= `UCB_FIFO_DEPTH && tx_count_reg <= `UCB_FIFO_DEPTH;
  endproperty
  a_cap: assert property (p_cap) else $error("buffer over depth");
  c_rx_push: cover property (@(posedge core_clk) disable iff (!nrst) rx_push && !rx_full);
  c_tx_done: cover property (@(posedge core_clk) disable iff (!nrst)
    tx_state_reg == ucb_pkg::UCB_TX_STOP ##1 tx_state_reg == ucb_pkg::UCB_TX_IDLE);
  c_irq: cover property (@(posedge core_clk) disable iff (!nrst) $rose(irq_out));
endmodule : ucb_uart
`default_nettype wire

// ### dv/ucb_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module ucb_line_model (
  // core clock, used to sample the baud pulses and to bound waits
  input wire logic core_clk,
  // device transmit side
  input wire logic serial_output,
  input wire logic baud_clock_out,
  // device receive side
  output logic serial_input,
  output logic receiver_clock_in
);
  initial begin
    serial_input = 1'b1;
    receiver_clock_in = 1'b0;
  end

  // free-running 16x receive clock at 12.5 MHz, phase unrelated to the core clock
  always #40 receiver_clock_in = ~receiver_clock_in;

  // start, data lsb first, one stop; each bit lasts 16 receive clocks
  task automatic send_char(input logic [7:0] data, input int nbits);
    logic b;
    for (int i = 0; i < nbits + 2; i++) begin
      b = (i == 0) ? 1'b0 : ((i <= nbits) ? data[i - 1] : 1'b1);
      @(posedge receiver_clock_in);
      serial_input <= b;
      repeat (15) @(posedge receiver_clock_in);
    end
  endtask : send_char

  // counts baud pulses at core edges; live drops if the pulses stop coming
  task automatic wait_baud(input int cnt, inout logic live);
    int seen;
    int k;
    seen = 0;
    k = 0;
    while (seen < cnt && k < 20000) begin
      @(posedge core_clk);
      k++;
      if (baud_clock_out === 1'b1) begin
        seen++;
      end
    end
    if (seen < cnt) begin
      live = 1'b0;
    end
  endtask : wait_baud

  // samples mid-bit by counting the 16x baud pulses, so bit timing is checked too
  task automatic recv_char(output logic [7:0] data, input int nbits, output logic ok);
    int n;
    logic live;
    data = 8'h00;
    ok = 1'b0;
    n = 0;
    live = 1'b1;
    while (serial_output !== 1'b0 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    if (n < 20000) begin
      wait_baud(8, live);
      for (int i = 0; i < nbits; i++) begin
        wait_baud(16, live);
        data[i] = serial_output;
      end
      wait_baud(16, live);
      ok = live && (serial_output === 1'b1);
    end
  endtask : recv_char
endmodule : ucb_line_model
`default_nettype wire

// ### dv/tb_uart_baud_and_char_buffers.sv
`include "ucb_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_uart_baud_and_char_buffers;
  localparam int REF_HZ = 12500000;
  logic core_clk, nrst, reg_wr, reg_rd, reference_clock_in, ok;
  logic serial_input, serial_output, baud_clock_out, irq_out, receiver_clock_in;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val, got, a, b;
  logic [15:0] dv;
  logic [7:0] q[$];
  int error_cnt, total_checks, seed, n, gap;

  ucb_uart i_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reference_clock_in(reference_clock_in), .receiver_clock_in(receiver_clock_in),
    .serial_input(serial_input), .serial_output(serial_output),
    .baud_clock_out(baud_clock_out), .irq_out(irq_out));

  ucb_line_model i_line (.core_clk(core_clk), .serial_output(serial_output),
    .baud_clock_out(baud_clock_out), .serial_input(serial_input),
    .receiver_clock_in(receiver_clock_in));

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;
  // 12.5 MHz reference keeps inside the 16 MHz ceiling; one period is 16 core cycles
  initial reference_clock_in = 1'b0;
  always #40 reference_clock_in = ~reference_clock_in;

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [2:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] ad, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd_reg

  // write then read the same address on the very next edge
  task automatic wr_rd_reg(input logic [2:0] ad, input logic [7:0] d, output logic [7:0] q_out);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    q_out = reg_rdata;
  endtask : wr_rd_reg

  function automatic logic [15:0] div_for(input int ref_hz, input int baud);
    return 16'(ref_hz / (baud * 16));
  endfunction : div_for

  task automatic set_div(input logic [15:0] d);
    wr_reg(`UCB_ADDR_DIV_LO, d[7:0]);
    wr_reg(`UCB_ADDR_DIV_HI, d[15:8]);
  endtask : set_div

  // bounded wait; a pulse is seen at 1 ns after the edge that raised it
  task automatic wait_sig(input bit which_irq);
    int k;
    k = 0;
    #1;
    while ((which_irq ? irq_out : baud_clock_out) !== 1'b1 && k < 6000) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k >= 6000) begin
      error_cnt++;
      close_out;
    end
    n = k;
  endtask : wait_sig

  task automatic baud_gap;
    wait_sig(1'b0);
    @(posedge core_clk);
    wait_sig(1'b0);
    gap = n + 1;
  endtask : baud_gap

  initial begin
    seed = 29323;
    error_cnt = 0;
    total_checks = 0;
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (4) @(posedge core_clk);
    #1;
    check({reg_rdata, serial_output, baud_clock_out, irq_out}, 16'h0004);
    @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      got = 8'($random(seed));
      if (i[0]) begin
        wr_rd_reg(`UCB_ADDR_SCRATCH, got, rd_val);
      end else begin
        wr_reg(`UCB_ADDR_SCRATCH, got);
        rd_reg(`UCB_ADDR_SCRATCH, rd_val);
      end
      check({rd_val, 7'h00, irq_out}, {got, 8'h00});
    end
    // empty receive buffer answers 0
    rd_reg(`UCB_ADDR_DATA, rd_val);
    check(rd_val, 8'h00);
    for (int d = 1; d <= 4; d++) begin
      dv = div_for(REF_HZ, REF_HZ / (16 * d));
      set_div(dv);
      baud_gap;
      baud_gap;
      check(gap, 16 * dv);
    end
    // a stale long count must not survive a latch write
    set_div(16'h0102);
    repeat (40) @(posedge core_clk);
    wr_reg(`UCB_ADDR_DIV_HI, 8'h00);
    wait_sig(1'b0);
    check(16'(n <= 40), 16'h0001);
    baud_gap;
    check(gap, 16'd32);
    set_div(div_for(REF_HZ, 781250));
    wr_reg(`UCB_ADDR_IRQ_EN, 8'h02);
    repeat (3) @(posedge core_clk);
    #1;
    check(irq_out, 1'b1);
    a = 8'($random(seed));
    b = 8'($random(seed));
    wr_reg(`UCB_ADDR_DATA, a);
    wr_reg(`UCB_ADDR_DATA, b);
    repeat (2) @(posedge core_clk);
    #1;
    check(irq_out, 1'b0);
    i_line.recv_char(got, 8, ok);
    check({got, 7'h00, ok}, {a, 8'h01});
    i_line.recv_char(got, 8, ok);
    check({got, 7'h00, ok}, {b, 8'h01});
    wait_sig(1'b1);
    check(irq_out, 1'b1);
    // seven-bit characters both ways
    wr_reg(`UCB_ADDR_LINE_CTL, 8'h02);
    wr_reg(`UCB_ADDR_IRQ_EN, 8'h01);
    a = 8'($random(seed));
    wr_reg(`UCB_ADDR_DATA, a);
    i_line.recv_char(got, 7, ok);
    check({got, 7'h00, ok}, {a & 8'h7F, 8'h01});
    check(irq_out, 1'b0);
    b = 8'($random(seed));
    i_line.send_char(b, 7);
    wait_sig(1'b1);
    rd_reg(`UCB_ADDR_DATA, rd_val);
    check(rd_val, b & 8'h7F);
    repeat (2) @(posedge core_clk);
    #1;
    check(irq_out, 1'b0);
    // seven bits, even parity, two stops: the parity bit lands in bit 7
    wr_reg(`UCB_ADDR_LINE_CTL, 8'h1E);
    a = 8'($random(seed)) & 8'h7F;
    wr_reg(`UCB_ADDR_DATA, a);
    i_line.recv_char(got, 8, ok);
    check({got, 7'h00, ok}, {^a, a[6:0], 8'h01});
    // the receive side gets a wrong parity bit on purpose
    b = 8'($random(seed)) & 8'h7F;
    i_line.send_char({~^b, b[6:0]}, 8);
    wait_sig(1'b1);
    rd_reg(`UCB_ADDR_LINE_STAT, rd_val);
    check(rd_val, 8'h65);
    rd_reg(`UCB_ADDR_DATA, rd_val);
    check(rd_val, b);
    // fifo mode, trigger level 4
    wr_reg(`UCB_ADDR_LINE_CTL, 8'h03);
    wr_reg(`UCB_ADDR_FIFO_CTL, 8'h47);
    for (int i = 0; i < 4; i++) begin
      a = 8'($random(seed));
      q.push_back(a);
      i_line.send_char(a, 8);
      repeat (40) @(posedge core_clk);
      #1;
      check(irq_out, (i == 3) ? 1'b1 : 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      rd_reg(`UCB_ADDR_DATA, rd_val);
      check(rd_val, q.pop_front());
    end
    repeat (2) @(posedge core_clk);
    #1;
    check(irq_out, 1'b0);
    close_out;
  end
endmodule : tb_uart_baud_and_char_buffers
`default_nettype wire
